// ===== camera_sensor_capture.sv
// Notes on behaviour
// R1: Gated mode frames pixels with both syncs.
// R2: Frame starts on chosen frame sync edge.
// R3: Sensor holds line sync high per line.
// R4: Gated pixels captured only while line sync high.
// R5: Latch edge opposite to sensor launch edge.
// R6: Non-gated mode ignores line sync entirely.
// R7: Pixels cross to system clock via buffer.
`include "cam_capture_cfg.svh"
`default_nettype none
module camera_sensor_capture #(
  parameter int DATA_W  = `CAM_DATA_W,
  parameter int FIFO_AW = `CAM_FIFO_AW
) (
  input  wire logic              sys_clk_in,      // System clock, 40 MHz
  input  wire logic              resetn_in,       // Async reset, active low
  input  wire logic              gated_mode_in,   // 1 gated, 0 non-gated
  input  wire logic              latch_fall_in,   // 1 latch on falling pixel edge
  input  wire logic              vsync_rise_in,   // 1 frame starts on rising sync
  input  wire logic              pix_clk_in,      // Sensor pixel clock
  input  wire logic              vsync_in,        // Sensor frame sync
  input  wire logic              hsync_in,        // Sensor line sync
  input  wire logic [DATA_W-1:0] pix_d_in,        // Sensor data bus
  output logic                   pix_valid_out,   // Pixel strobe, system clock
  output logic [DATA_W-1:0]      pix_data_out,    // Pixel value
  output logic                   frame_start_out  // First pixel of a frame
);

  ////////////////////////////////////////////////////////////////////////
  // Pixel-domain reset: asserts at once, releases on the pixel clock
  logic pix_rst_meta_reg;
  logic pix_rst_n_reg;

  always_ff @(posedge pix_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pix_rst_meta_reg <= 1'b0;
      pix_rst_n_reg    <= 1'b0;
    end else begin
      pix_rst_meta_reg <= 1'b1;
      pix_rst_n_reg    <= pix_rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Static configuration into the pixel domain, two flops each
  logic [2:0] cfg_meta_reg;
  logic [2:0] cfg_sync_reg;
  logic       gated_s;
  logic       fall_s;
  logic       rise_s;

  always_ff @(posedge pix_clk_in or negedge pix_rst_n_reg) begin
    if (!pix_rst_n_reg) begin
      cfg_meta_reg <= 3'h0;
      cfg_sync_reg <= 3'h0;
    end else begin
      cfg_meta_reg <= {gated_mode_in, latch_fall_in, vsync_rise_in};
      cfg_sync_reg <= cfg_meta_reg;
    end
  end

  assign gated_s = cfg_sync_reg[2];
  assign fall_s  = cfg_sync_reg[1];
  assign rise_s  = cfg_sync_reg[0];

  ////////////////////////////////////////////////////////////////////////
  // Sensor pins sampled on both pixel edges; the sensor launches on one
  // edge so the other edge sees stable data
  logic              pos_vs_reg;
  logic              pos_hs_reg;
  logic [DATA_W-1:0] pos_d_reg;
  logic              neg_vs_reg;
  logic              neg_hs_reg;
  logic [DATA_W-1:0] neg_d_reg;

  always_ff @(posedge pix_clk_in or negedge pix_rst_n_reg) begin
    if (!pix_rst_n_reg) begin
      pos_vs_reg <= `CAM_RST_BIT;
      pos_hs_reg <= `CAM_RST_BIT;
      pos_d_reg  <= '0;
    end else begin
      pos_vs_reg <= vsync_in;
      pos_hs_reg <= hsync_in;
      pos_d_reg  <= pix_d_in;
    end
  end

  always_ff @(negedge pix_clk_in or negedge pix_rst_n_reg) begin
    if (!pix_rst_n_reg) begin
      neg_vs_reg <= `CAM_RST_BIT;
      neg_hs_reg <= `CAM_RST_BIT;
      neg_d_reg  <= '0;
    end else begin
      neg_vs_reg <= vsync_in;
      neg_hs_reg <= hsync_in;
      neg_d_reg  <= pix_d_in;
    end
  end

  // R5: latch edge select
  // Falling-edge samples are half a cycle old at the next rising edge
  logic              s_vs;
  logic              s_hs;
  logic [DATA_W-1:0] s_d;

  assign s_vs = fall_s ? neg_vs_reg : pos_vs_reg;
  assign s_hs = fall_s ? neg_hs_reg : pos_hs_reg;
  assign s_d  = fall_s ? neg_d_reg : pos_d_reg;

  ////////////////////////////////////////////////////////////////////////
  // Frame tracking
  cam_capture_pkg::frame_state_e fr_state_reg;
  logic                          vs_prev_reg;
  logic                          frame_start;
  logic                          vs_active;

  // R2: frame start on selected sync transition
  assign frame_start = rise_s ? (s_vs && !vs_prev_reg) : (!s_vs && vs_prev_reg);
  assign vs_active   = rise_s ? s_vs : !s_vs;

  always_ff @(posedge pix_clk_in or negedge pix_rst_n_reg) begin
    if (!pix_rst_n_reg) begin
      vs_prev_reg <= `CAM_RST_BIT;
    end else begin
      vs_prev_reg <= s_vs;
    end
  end

  // No pixel is taken before the first frame start after reset
  always_ff @(posedge pix_clk_in or negedge pix_rst_n_reg) begin
    if (!pix_rst_n_reg) begin
      fr_state_reg <= cam_capture_pkg::FR_WAIT;
    end else begin
      case (fr_state_reg)
        cam_capture_pkg::FR_WAIT: begin
          if (frame_start) begin
            fr_state_reg <= cam_capture_pkg::FR_FRAME;
          end
        end
        cam_capture_pkg::FR_FRAME: begin
          fr_state_reg <= cam_capture_pkg::FR_FRAME;
        end
        default: begin
          fr_state_reg <= cam_capture_pkg::FR_WAIT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pixel qualification
  logic pix_take;
  logic wr_ready;
  logic wr_valid;
  logic sof_pend_reg;
  cam_capture_pkg::pix_word_s wr_word;

  // R1: gated mode uses both syncs
  // R4: line sync gates pixels
  // R6: non-gated ignores line sync
  // The edge that starts a frame carries no pixel
  assign pix_take = (fr_state_reg == cam_capture_pkg::FR_FRAME) && !frame_start &&
                    (gated_s ? s_hs : vs_active);
  // A full buffer drops the pixel; cannot fill while pixel clock <= half system clock
  assign wr_valid = pix_take;
  assign wr_word  = '{sof: sof_pend_reg, data: s_d};

  // Start marker rides on the first pixel taken after a frame start
  always_ff @(posedge pix_clk_in or negedge pix_rst_n_reg) begin
    if (!pix_rst_n_reg) begin
      sof_pend_reg <= `CAM_RST_BIT;
    end else if (frame_start) begin
      sof_pend_reg <= 1'b1;
    end else if (wr_valid && wr_ready) begin
      sof_pend_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // R7: clock crossing buffer
  logic                       rd_valid;
  cam_capture_pkg::pix_word_s rd_word;

  cam_cdc_fifo #(
    .WIDTH ($bits(cam_capture_pkg::pix_word_s)),
    .AW    (FIFO_AW)
  ) u_cdc (
    .wclk_in    (pix_clk_in),
    .wrst_n_in  (pix_rst_n_reg),
    .wvalid_in  (wr_valid),
    .wready_out (wr_ready),
    .wdata_in   (wr_word),
    .rclk_in    (sys_clk_in),
    .rrst_n_in  (resetn_in),
    .rvalid_out (rd_valid),
    .rready_in  (1'b1),
    .rdata_out  (rd_word)
  );

  ////////////////////////////////////////////////////////////////////////
  // System-side output flops; one word per cycle drains the buffer
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pix_valid_out   <= `CAM_RST_BIT;
      pix_data_out    <= '0;
      frame_start_out <= `CAM_RST_BIT;
    end else begin
      pix_valid_out   <= rd_valid;
      frame_start_out <= rd_valid && rd_word.sof;
      if (rd_valid) begin
        pix_data_out <= rd_word.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks, pixel domain
  a_gated_hsync_gate: assert property ( // R4
    @(posedge pix_clk_in) disable iff (!pix_rst_n_reg)
    (gated_s && !s_hs) |-> !wr_valid)
    else $error("pixel taken with line sync low in gated mode");

  a_gated_needs_frame: assert property ( // R1
    @(posedge pix_clk_in) disable iff (!pix_rst_n_reg)
    (gated_s && wr_valid) |-> (fr_state_reg == cam_capture_pkg::FR_FRAME) && s_hs)
    else $error("gated pixel outside frame or line");

  a_nongated_take_all: assert property ( // R6
    @(posedge pix_clk_in) disable iff (!pix_rst_n_reg)
    (!gated_s && (fr_state_reg == cam_capture_pkg::FR_FRAME) && !frame_start &&
     vs_active) |-> wr_valid)
    else $error("non-gated pixel not taken");

  a_frame_start_arms: assert property ( // R2
    @(posedge pix_clk_in) disable iff (!pix_rst_n_reg)
    frame_start |=> (fr_state_reg == cam_capture_pkg::FR_FRAME) && sof_pend_reg)
    else $error("frame start did not arm capture");

  a_no_pix_before_frame: assert property ( // R2
    @(posedge pix_clk_in) disable iff (!pix_rst_n_reg)
    (fr_state_reg == cam_capture_pkg::FR_WAIT) |-> !wr_valid)
    else $error("pixel taken before first frame start");

  a_rise_latch_data: assert property ( // R5
    @(posedge pix_clk_in) disable iff (!pix_rst_n_reg)
    (!fall_s && wr_valid) |-> (wr_word.data == $past(pix_d_in)))
    else $error("rising-edge latch took wrong data");

  a_sof_one_pixel: assert property ( // R2
    @(posedge pix_clk_in) disable iff (!pix_rst_n_reg)
    (wr_valid && wr_ready && !frame_start) |=> !sof_pend_reg)
    else $error("start marker stuck after first pixel");

  // Independent falling-edge copy of the data pins; catches a wrong latch mux
  logic [DATA_W-1:0] chk_neg_d_reg;

  always_ff @(negedge pix_clk_in) begin
    chk_neg_d_reg <= pix_d_in;
  end

  a_fall_latch_data: assert property ( // R5
    @(posedge pix_clk_in) disable iff (!pix_rst_n_reg)
    (fall_s && wr_valid) |-> (wr_word.data == chk_neg_d_reg))
    else $error("falling-edge latch took wrong data");

  a_frame_rise_edge: assert property ( // R2
    @(posedge pix_clk_in) disable iff (!pix_rst_n_reg)
    (rise_s && $rose(s_vs)) |-> frame_start)
    else $error("rising frame sync edge missed");

  a_frame_fall_edge: assert property ( // R2
    @(posedge pix_clk_in) disable iff (!pix_rst_n_reg)
    (!rise_s && $fell(s_vs)) |-> frame_start)
    else $error("falling frame sync edge missed");

  a_nongated_needs_vs: assert property ( // R6
    @(posedge pix_clk_in) disable iff (!pix_rst_n_reg)
    (!gated_s && wr_valid) |-> vs_active && (fr_state_reg == cam_capture_pkg::FR_FRAME))
    else $error("non-gated pixel outside active frame sync");

  // Pixel clock at most half the system clock keeps the buffer from filling
  a_no_fifo_drop: assert property ( // R7
    @(posedge pix_clk_in) disable iff (!pix_rst_n_reg)
    wr_valid |-> wr_ready)
    else $error("pixel dropped on a full buffer");

  // Checks, system domain
  a_cross_deliver: assert property ( // R7
    @(posedge sys_clk_in) disable iff (!resetn_in)
    rd_valid |=> pix_valid_out && (pix_data_out == $past(rd_word.data)))
    else $error("buffered pixel not delivered next cycle");

  a_cross_idle: assert property ( // R7
    @(posedge sys_clk_in) disable iff (!resetn_in)
    !rd_valid |=> !pix_valid_out && !frame_start_out)
    else $error("output strobe with empty buffer");

  c_frame_start: cover property (
    @(posedge pix_clk_in) disable iff (!pix_rst_n_reg) frame_start);
  c_gated_pixel: cover property (
    @(posedge pix_clk_in) disable iff (!pix_rst_n_reg) gated_s && wr_valid);
  c_nongated_pixel: cover property (
    @(posedge pix_clk_in) disable iff (!pix_rst_n_reg) !gated_s && wr_valid);
  c_fall_latch_pixel: cover property (
    @(posedge pix_clk_in) disable iff (!pix_rst_n_reg) fall_s && wr_valid);
  c_sys_frame_out: cover property (
    @(posedge sys_clk_in) disable iff (!resetn_in) frame_start_out);

endmodule // camera_sensor_capture
`default_nettype wire

// ===== cam_capture_cfg.svh
`ifndef CAM_CAPTURE_CFG_SVH
`define CAM_CAPTURE_CFG_SVH

// Width of the sensor data bus
`define CAM_DATA_W 8
// Log2 of the crossing buffer depth
`define CAM_FIFO_AW 3
// Reset values of the output flops and the captured samples
`define CAM_RST_DATA 8'h00
`define CAM_RST_BIT 1'b0
// Least spacing of frame sync to first line or pixel, in system clocks
`define CAM_VS_TO_PIX_CYC 9

`endif

// ===== cam_capture_pkg.sv
`include "cam_capture_cfg.svh"
`default_nettype none
package cam_capture_pkg;

  // One captured pixel with its start-of-frame marker
  typedef struct packed {
    logic                   sof;
    logic [`CAM_DATA_W-1:0] data;
  } pix_word_s;

  // Pixel-side frame tracker states, one-hot
  typedef enum logic [1:0] {
    FR_WAIT  = 2'b01,
    FR_FRAME = 2'b10
  } frame_state_e;

endpackage
`default_nettype wire

// ===== cam_cdc_fifo.sv
`default_nettype none
module cam_cdc_fifo #(
  parameter int WIDTH = 9,
  parameter int AW    = 3
) (
  input  wire logic             wclk_in,    // Writer clock
  input  wire logic             wrst_n_in,  // Writer reset, active low
  input  wire logic             wvalid_in,  // Write request
  output logic                  wready_out, // Not full
  input  wire logic [WIDTH-1:0] wdata_in,   // Write word
  input  wire logic             rclk_in,    // Reader clock
  input  wire logic             rrst_n_in,  // Reader reset, active low
  output logic                  rvalid_out, // Not empty
  input  wire logic             rready_in,  // Read accept
  output logic [WIDTH-1:0]      rdata_out   // Head word
);

  logic [WIDTH-1:0] mem [0:(1<<AW)-1];
  logic [AW:0]      wbin_reg;
  logic [AW:0]      wgray_reg;
  logic [AW:0]      rbin_reg;
  logic [AW:0]      rgray_reg;
  logic [AW:0]      rg_meta_reg;
  logic [AW:0]      rg_sync_reg;
  logic [AW:0]      wg_meta_reg;
  logic [AW:0]      wg_sync_reg;
  logic [AW:0]      wbin_next;
  logic [AW:0]      rbin_next;

  // Full compares gray pointers with the top two bits inverted
  assign wready_out = (wgray_reg != {~rg_sync_reg[AW:AW-1], rg_sync_reg[AW-2:0]});
  assign rvalid_out = (rgray_reg != wg_sync_reg);
  assign rdata_out  = mem[rbin_reg[AW-1:0]];
  assign wbin_next  = wbin_reg + {{AW{1'b0}}, 1'b1};
  assign rbin_next  = rbin_reg + {{AW{1'b0}}, 1'b1};

  ////////////////////////////////////////////////////////////////////////
  // Write side
  always_ff @(posedge wclk_in) begin
    if (wvalid_in && wready_out) begin
      mem[wbin_reg[AW-1:0]] <= wdata_in;
    end
  end

  always_ff @(posedge wclk_in or negedge wrst_n_in) begin
    if (!wrst_n_in) begin
      wbin_reg  <= '0;
      wgray_reg <= '0;
    end else if (wvalid_in && wready_out) begin
      wbin_reg  <= wbin_next;
      wgray_reg <= wbin_next ^ (wbin_next >> 1);
    end
  end

  // Read pointer into the writer domain; only gray words cross
  always_ff @(posedge wclk_in or negedge wrst_n_in) begin
    if (!wrst_n_in) begin
      rg_meta_reg <= '0;
      rg_sync_reg <= '0;
    end else begin
      rg_meta_reg <= rgray_reg;
      rg_sync_reg <= rg_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read side
  always_ff @(posedge rclk_in or negedge rrst_n_in) begin
    if (!rrst_n_in) begin
      rbin_reg  <= '0;
      rgray_reg <= '0;
    end else if (rvalid_out && rready_in) begin
      rbin_reg  <= rbin_next;
      rgray_reg <= rbin_next ^ (rbin_next >> 1);
    end
  end

  always_ff @(posedge rclk_in or negedge rrst_n_in) begin
    if (!rrst_n_in) begin
      wg_meta_reg <= '0;
      wg_sync_reg <= '0;
    end else begin
      wg_meta_reg <= wgray_reg;
      wg_sync_reg <= wg_meta_reg;
    end
  end

endmodule // cam_cdc_fifo
`default_nettype wire

// ===== cam_sensor_model.sv
`include "cam_capture_cfg.svh"
`default_nettype none
module cam_sensor_model (
  input  wire logic              launch_rise_in, // 1 sensor launches on rising edge
  input  wire logic              vs_high_in,     // Frame sync active level
  output logic                   pix_clk_out,    // Free-running pixel clock
  output logic                   vsync_out,      // Frame sync
  output logic                   hsync_out,      // Line sync
  output logic [`CAM_DATA_W-1:0] pix_d_out       // Pixel data
);
  timeunit 1ns;
  timeprecision 100ps;

  // Pixel clock, 125 ns, offset so it never lines up with the system clock
  initial begin
    pix_clk_out = 1'b0;
    vsync_out = 1'b0;
    hsync_out = 1'b0;
    pix_d_out = '0;
    #7;
    forever #62.5 pix_clk_out = ~pix_clk_out;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // launch edge: change lines just after the launch edge, half a period before latch
  task automatic step();
    if (launch_rise_in) @(posedge pix_clk_out);
    else @(negedge pix_clk_out);
    #1;
  endtask

  // Idle: data toggles so a stale value never passes as a pixel
  task automatic idle();
    hsync_out = 1'b0;
    repeat (3) begin
      step();
      pix_d_out = ~pix_d_out;
    end
    vsync_out = ~vs_high_in;
    repeat (4) begin
      step();
      pix_d_out = ~pix_d_out;
    end
  endtask

  // Line without any frame start, must be dropped
  task automatic line_only(input int npix);
    for (int n = 0; n < npix; n++) begin
      step();
      hsync_out = 1'b1;
      pix_d_out = `CAM_DATA_W'(n + 3);
    end
    step();
    hsync_out = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // frame edge: frame opens with the active frame sync transition
  // line framing: gated frames hold line sync high over every pixel, gap each fourth slot; non-gated frames toggle it
  task automatic frame(input bit gated, input int npix, input logic [7:0] base);
    step();
    vsync_out = vs_high_in;
    pix_d_out = ~pix_d_out;
    // Two idle periods give more than nine system clocks before the first line
    if (gated) repeat (2) begin
      step();
      pix_d_out = ~pix_d_out;
    end
    for (int n = 0; n < npix; n++) begin
      step();
      hsync_out = gated ? logic'(n % 4 != 3) : n[0];
      if (gated && n % 4 == 3) pix_d_out = ~pix_d_out;
      else pix_d_out = base + `CAM_DATA_W'(n);
    end
    step();
    hsync_out = 1'b0;
    vsync_out = ~vs_high_in;
    pix_d_out = ~pix_d_out;
  endtask
endmodule // cam_sensor_model
`default_nettype wire

// ===== test_camera_sensor_capture.sv
`include "cam_capture_cfg.svh"
`default_nettype none
module test_camera_sensor_capture;
  timeunit 1ns;
  timeprecision 100ps;

  `define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp); end end

  logic                   sys_clk_in = 1'b0;
  logic                   resetn_in = 1'b0;
  logic                   gated_mode_in = 1'b1;
  logic                   latch_fall_in = 1'b0;
  logic                   vsync_rise_in = 1'b1;
  wire logic              pix_clk;
  wire logic              vsync;
  wire logic              hsync;
  wire logic [7:0]        pix_d;
  logic                   pix_valid;
  logic [7:0]             pix_data;
  logic                   frame_start;
  int                     miscompares = 0;
  int                     n_checks = 0;
  cam_capture_pkg::pix_word_s rx[$];

  // System clock, 40 MHz
  always #12.5 sys_clk_in = ~sys_clk_in;

  camera_sensor_capture i_camera_sensor_capture (
    .sys_clk_in      (sys_clk_in),
    .resetn_in       (resetn_in),
    .gated_mode_in   (gated_mode_in),
    .latch_fall_in   (latch_fall_in),
    .vsync_rise_in   (vsync_rise_in),
    .pix_clk_in      (pix_clk),
    .vsync_in        (vsync),
    .hsync_in        (hsync),
    .pix_d_in        (pix_d),
    .pix_valid_out   (pix_valid),
    .pix_data_out    (pix_data),
    .frame_start_out (frame_start)
  );

  // Sensor launches on the edge opposite to the capture latch edge
  cam_sensor_model i_cam_sensor_model (
    .launch_rise_in (latch_fall_in),
    .vs_high_in     (vsync_rise_in),
    .pix_clk_out    (pix_clk),
    .vsync_out      (vsync),
    .hsync_out      (hsync),
    .pix_d_out      (pix_d)
  );

  // Collect mid-cycle, away from the edge that launches the one-cycle strobes
  always @(negedge sys_clk_in) begin
    if (pix_valid === 1'b1) rx.push_back({frame_start, pix_data});
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Config settles three launch edges before the sensor moves frame sync
  task automatic set_cfg(input logic g, input logic f, input logic r);
    @(posedge sys_clk_in);
    #2;
    gated_mode_in = g;
    latch_fall_in = f;
    vsync_rise_in = r;
    i_cam_sensor_model.idle();
  endtask

  // One frame in, then compare order, values and the frame marker
  task automatic run_frame(input bit gated, input int npix, input logic [7:0] base);
    int k;
    int exp_n;
    k = 0;
    exp_n = 0;
    for (int n = 0; n < npix; n++) if (!gated || n % 4 != 3) exp_n++;
    rx.delete();
    i_cam_sensor_model.frame(gated, npix, base);
    for (int w = 0; w < 80 && rx.size() < exp_n; w++) @(posedge sys_clk_in);
    // Extra time so a surplus pixel would still show up
    repeat (12) @(posedge sys_clk_in);
    `CHK(rx.size(), exp_n)
    for (int n = 0; n < npix && k < rx.size(); n++) begin
      if (gated && n % 4 == 3) continue;
      `CHK(rx[k].data, base + 8'(n))
      `CHK(rx[k].sof, k == 0)
      k++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_no_frame();
    set_cfg(1'b1, 1'b0, 1'b1);
    rx.delete();
    i_cam_sensor_model.line_only(6);
    repeat (40) @(posedge sys_clk_in);
    `CHK(rx.size(), 0)
  endtask

  // Two frames in a row, the second begins once the first frame's pixels are collected
  task automatic t_gated_rise();
    set_cfg(1'b1, 1'b0, 1'b1);
    run_frame(1'b1, 12, 8'h10);
    run_frame(1'b1, 8, 8'hf0);
  endtask

  task automatic t_gated_fall();
    set_cfg(1'b1, 1'b1, 1'b0);
    run_frame(1'b1, 12, 8'h40);
  endtask

  // Line sync toggles throughout; every sample inside the frame counts
  task automatic t_nongated();
    set_cfg(1'b0, 1'b0, 1'b1);
    run_frame(1'b0, 10, 8'ha0);
    set_cfg(1'b0, 1'b1, 1'b0);
    run_frame(1'b0, 9, 8'h20);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge sys_clk_in);
    #2;
    `CHK(pix_valid, 1'b0)
    resetn_in = 1'b1;
    t_no_frame();
    t_gated_rise();
    t_gated_fall();
    t_nongated();
    final_report();
  end

  // Watchdog, well beyond the roughly 17 us the scenarios need
  initial begin
    #200us;
    miscompares++;
    final_report();
  end
endmodule // test_camera_sensor_capture
`default_nettype wire
